// ### hdl/star_delta_reversing_starter_seq.sv
// Sequencer for a reversing star-delta open-transition motor starter.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// RULE1: Ready stays off and starts are refused until all faults are cleared.
// RULE2: Ready needs the hardwired stop input present at its valid level.
// RULE3: With drawer supervision enabled, ready needs the supervision input active.
// RULE4: Fieldbus selection: telegram bit 9 picks local, bit 10 picks remote.
// RULE5: Serial selection: coil 10 write picks local, coil 11 picks remote.
// RULE6: Hardwire selection: one input picks local, another picks remote.
// RULE7: Local lets every local source start/stop; remote lets only the remote source.
// RULE8: Fixed local always allows local sources; fixed remote only the remote one.
// RULE9: Local and remote both active forces ready off and blocks starts.
// RULE10: Configuration writes take effect only while parameter change is permitted.
// RULE11: Forward start first energizes the star contactor.
// RULE12: Star feedback then energizes the forward line contactor.
// RULE13: Star opens on maximum-on timeout or when current drops below threshold.
// RULE14: Delta closes only after star feedback is gone and switchover time elapses.
// RULE15: Stop while forward opens forward line, delta and star together.
// RULE16: Reverse start runs the same sequence with the reverse line contactor.
// RULE17: Stop while reverse opens delta, reverse line and star together.
// RULE18: Star maximum-on and switchover times each have their own register.
// RULE19: Config bit 0 set with type 0x3 applies the default input mapping.
// RULE20: Default mapping: stop input active low, start inputs active high.
// RULE21: Shared output shows ready first, else flashes the identification pattern.
// RULE22: Starts are ignored while running or not ready; line contactors never both on.
module star_delta_reversing_starter_seq #(
    parameter int unsigned TICK_CYCLES_P = starter_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   nrst_i,
    // Hardwired pins and contactor feedback
    input  wire starter_pkg::hw_in_t    hw_i,
    // Metering and fault logic
    input  wire logic [15:0]            current_i,
    input  wire logic                   fault_event_i,
    // Serial register access
    input  wire starter_pkg::reg_wr_t   reg_wr_i,
    input  wire starter_pkg::coil_wr_t  coil_wr_i,
    input  wire logic [15:0]            rd_addr_i,
    output logic      [15:0]            rd_data_o,
    // Fieldbus telegram
    input  wire starter_pkg::telegram_t telegram_i,
    // Contactor coils and indications
    output starter_pkg::coils_t         coils_o,
    output logic                        ready_ident_o,
    output logic                        local_ctrl_o,
    output logic                        fault_o
);
    import starter_pkg::*;

    typedef struct packed {
        logic [15:0] thresh;
        logic [15:0] star_max;
        logic [15:0] sw_time;
        logic [15:0] cfg;
        logic        loc;
        logic        rem;
        logic        fault;
        logic        ident;
        logic        flash;
        logic [15:0] flash_cnt;
        seq_state_t  seq;
        logic        dir;
        logic [31:0] tick_cnt;
        logic [15:0] tim;
        logic        fwd_prev;
        logic        rev_prev;
        logic        ready;
        coils_t      coils;
        logic [15:0] rd_data;
    } state_t;

    state_t s_q;
    state_t s_d;
    hw_in_t hw_s;

    logic     tick;
    logic     default_map;
    logic     stop_act;
    logic     fwd_lvl;
    logic     rev_lvl;
    logic     ready;
    logic     param_ok;
    logic     fwd_req;
    logic     rev_req;
    logic     stop_req;
    logic     fault_clr;
    logic     low_current;
    cmd_src_t rsrc;
    sel_src_t sel;

    if (TICK_CYCLES_P < 1) begin : g_bad_tick
        $error("TICK_CYCLES_P must be at least one.");
    end

    function automatic logic src_allowed(input cmd_src_t src, input logic loc,
                                         input logic rem, input cmd_src_t remote);
        src_allowed = (loc & ~rem & (src != remote)) | (rem & ~loc & (src == remote));
    endfunction

    function automatic logic in_fault_range(input logic [15:0] addr);
        in_fault_range = (addr >= FAULT_CLEAR_FIRST_ADDR) && (addr <= FAULT_CLEAR_LAST_ADDR);
    endfunction

    pin_sync #(
        .WIDTH ($bits(hw_in_t))
    ) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .d_i       (hw_i),
        .q_o       (hw_s)
    );

    always_comb begin
        s_d  = s_q;
        tick = (s_q.tick_cnt == 32'(TICK_CYCLES_P - 1));
        rsrc = cmd_src_t'(s_q.cfg[CFG_REMOTE_LSB +: 2]);
        sel  = sel_src_t'(s_q.cfg[CFG_SEL_LSB +: 3]);
        param_ok = s_q.cfg[CFG_PARAM_OK_BIT];
        // Outside the default mapping software may invert the input senses.
        default_map = s_q.cfg[CFG_DEFAULT_BIT] &&
                      (s_q.cfg[CFG_TYPE_LSB +: 4] == TYPE_STAR_DELTA_REV); // see RULE19
        stop_act = (~default_map & s_q.cfg[CFG_STOP_INV_BIT]) ? hw_s.stop_n
                                                              : ~hw_s.stop_n; // see RULE20
        fwd_lvl  = hw_s.fwd_start ^ (~default_map & s_q.cfg[CFG_START_INV_BIT]); // see RULE20
        rev_lvl  = hw_s.rev_start ^ (~default_map & s_q.cfg[CFG_START_INV_BIT]);
        low_current = current_i < s_q.thresh;

        s_d.tick_cnt = tick ? 32'h00000000 : 32'(s_q.tick_cnt + 32'h00000001);
        s_d.fwd_prev = fwd_lvl;
        s_d.rev_prev = rev_lvl;

        // The fault flag is set by an event even in the cycle it is cleared.
        fault_clr = hw_s.reset_alarm | (reg_wr_i.wr & in_fault_range(reg_wr_i.addr));
        s_d.fault = fault_event_i | (s_q.fault & ~fault_clr); // see RULE1

        ready = ~s_q.fault                                  // see RULE1
              & ~stop_act                                   // see RULE2
              & (~s_q.cfg[CFG_SUPERV_BIT] | hw_s.superv)    // see RULE3
              & (s_q.loc ^ s_q.rem);                        // see RULE9
        s_d.ready = ready;

        // Register writes; the permission bit itself stays writable.
        if (reg_wr_i.wr) begin
            if (reg_wr_i.addr == DEVICE_CONFIGURATION_ADDR) begin
                if (param_ok) begin
                    s_d.cfg = reg_wr_i.data; // see RULE10
                end else begin
                    s_d.cfg[CFG_PARAM_OK_BIT] = reg_wr_i.data[CFG_PARAM_OK_BIT];
                end
            end
            if (param_ok && reg_wr_i.addr == CURRENT_DROP_THRESHOLD_ADDR) begin
                s_d.thresh = reg_wr_i.data; // see RULE10
            end
            if (param_ok && reg_wr_i.addr == STAR_MAX_ON_TIME_ADDR) begin
                s_d.star_max = reg_wr_i.data; // see RULE18
            end
            if (param_ok && reg_wr_i.addr == STAR_TO_DELTA_SWITCH_TIME_ADDR) begin
                s_d.sw_time = reg_wr_i.data; // see RULE18
            end
        end

        // Local/remote selection from the configured source.
        case (sel)
            SEL_FIELDBUS: begin
                if (telegram_i.valid) begin
                    s_d.loc = telegram_i.word[TG_LOCAL_BIT]; // see RULE4
                    s_d.rem = telegram_i.word[TG_REMOTE_BIT];
                end
            end
            SEL_SERIAL: begin
                if (coil_wr_i.wr && coil_wr_i.val && coil_wr_i.addr == COIL_SEL_LOCAL) begin
                    s_d.loc = 1'b1; // see RULE5
                    s_d.rem = 1'b0;
                end
                if (coil_wr_i.wr && coil_wr_i.val && coil_wr_i.addr == COIL_SEL_REMOTE) begin
                    s_d.loc = 1'b0; // see RULE5
                    s_d.rem = 1'b1;
                end
            end
            SEL_HARDWIRE: begin
                s_d.loc = hw_s.sel_local; // see RULE6
                s_d.rem = hw_s.sel_remote;
            end
            SEL_FIXED_LOCAL: begin
                s_d.loc = 1'b1; // see RULE8
                s_d.rem = 1'b0;
            end
            SEL_FIXED_REMOTE: begin
                s_d.loc = 1'b0; // see RULE8
                s_d.rem = 1'b1;
            end
            default: begin
                s_d.loc = 1'b0;
                s_d.rem = 1'b0;
            end
        endcase

        // Commands, each gated by whether its source may act now.
        fwd_req = (src_allowed(SRC_HARDWIRE, s_q.loc, s_q.rem, rsrc) & fwd_lvl & ~s_q.fwd_prev)
                | (src_allowed(SRC_SERIAL, s_q.loc, s_q.rem, rsrc) & coil_wr_i.wr
                   & coil_wr_i.val & (coil_wr_i.addr == COIL_FWD_START))
                | (src_allowed(SRC_FIELDBUS, s_q.loc, s_q.rem, rsrc) & telegram_i.valid
                   & telegram_i.word[TG_FWD_BIT]); // see RULE7
        rev_req = (src_allowed(SRC_HARDWIRE, s_q.loc, s_q.rem, rsrc) & rev_lvl & ~s_q.rev_prev)
                | (src_allowed(SRC_SERIAL, s_q.loc, s_q.rem, rsrc) & coil_wr_i.wr
                   & coil_wr_i.val & (coil_wr_i.addr == COIL_REV_START))
                | (src_allowed(SRC_FIELDBUS, s_q.loc, s_q.rem, rsrc) & telegram_i.valid
                   & telegram_i.word[TG_REV_BIT]); // see RULE7
        // The hardwired stop and any fault always stop, whatever the selection.
        stop_req = stop_act | s_q.fault
                 | (src_allowed(SRC_SERIAL, s_q.loc, s_q.rem, rsrc) & coil_wr_i.wr
                    & coil_wr_i.val & (coil_wr_i.addr == COIL_STOP))
                 | (src_allowed(SRC_FIELDBUS, s_q.loc, s_q.rem, rsrc) & telegram_i.valid
                    & telegram_i.word[TG_STOP_BIT]); // see RULE7

        if (coil_wr_i.wr && coil_wr_i.addr == COIL_IDENT) begin
            s_d.ident = coil_wr_i.val;
        end
        if (tick) begin
            if (s_q.flash_cnt >= FLASH_TICKS) begin
                s_d.flash_cnt = 16'h0000;
                s_d.flash     = ~s_q.flash;
            end else begin
                s_d.flash_cnt = 16'(s_q.flash_cnt + 16'h0001);
            end
        end

        // Start sequence.
        case (s_q.seq)
            ST_IDLE: begin
                s_d.tim = 16'h0000;
                // Simultaneous forward and reverse requests are both ignored.
                if (ready && fwd_req && !rev_req) begin
                    s_d.seq = ST_STAR; // see RULE11
                    s_d.dir = 1'b0;
                end else if (ready && rev_req && !fwd_req) begin
                    s_d.seq = ST_STAR; // see RULE16
                    s_d.dir = 1'b1;
                end
            end
            ST_STAR: begin
                if (hw_s.star_fb) begin
                    s_d.seq = ST_LINE; // see RULE12
                    s_d.tim = 16'h0000;
                end
            end
            ST_LINE: begin
                if (tick) begin
                    s_d.tim = 16'(s_q.tim + 16'h0001);
                end
                if (s_q.tim >= s_q.star_max || low_current) begin
                    s_d.seq = ST_GAP; // see RULE13
                    s_d.tim = 16'h0000;
                end
            end
            ST_GAP: begin
                if (hw_s.star_fb) begin
                    s_d.tim = 16'h0000; // see RULE14
                end else if (s_q.tim >= s_q.sw_time) begin
                    s_d.seq = ST_DELTA; // see RULE14
                end else if (tick) begin
                    s_d.tim = 16'(s_q.tim + 16'h0001);
                end
            end
            ST_DELTA: begin
                s_d.tim = 16'h0000;
            end
            default: begin
                s_d.seq = ST_IDLE;
            end
        endcase
        if (s_q.seq != ST_IDLE && stop_req) begin
            s_d.seq = ST_IDLE; // see RULE15 see RULE17
        end

        // Coils follow the next state so they switch on the same edge.
        s_d.coils.star_contactor  = (s_d.seq == ST_STAR) || (s_d.seq == ST_LINE); // see RULE11
        s_d.coils.delta_contactor = (s_d.seq == ST_DELTA); // see RULE14
        s_d.coils.forward_line_contactor = ~s_d.dir &
            ((s_d.seq == ST_LINE) || (s_d.seq == ST_GAP) || (s_d.seq == ST_DELTA)); // see RULE22
        s_d.coils.reverse_line_contactor = s_d.dir &
            ((s_d.seq == ST_LINE) || (s_d.seq == ST_GAP) || (s_d.seq == ST_DELTA)); // see RULE16

        case (rd_addr_i)
            CURRENT_DROP_THRESHOLD_ADDR:    s_d.rd_data = s_q.thresh;
            STAR_MAX_ON_TIME_ADDR:          s_d.rd_data = s_q.star_max;
            STAR_TO_DELTA_SWITCH_TIME_ADDR: s_d.rd_data = s_q.sw_time;
            DEVICE_CONFIGURATION_ADDR:      s_d.rd_data = s_q.cfg;
            SEQ_STATUS_ADDR: s_d.rd_data = {5'h00, s_q.fault, s_q.rem, s_q.loc,
                                            s_q.ready, s_q.dir, 1'b0, s_q.seq};
            default:                        s_d.rd_data = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q          <= '0;
            s_q.thresh   <= CURRENT_DROP_THRESHOLD_RST;
            s_q.star_max <= STAR_MAX_ON_TIME_RST;
            s_q.sw_time  <= STAR_TO_DELTA_SWITCH_TIME_RST;
            s_q.cfg      <= DEVICE_CONFIGURATION_RST;
            s_q.seq      <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign coils_o       = s_q.coils;
    assign ready_ident_o = s_q.ready | (s_q.ident & s_q.flash); // see RULE21
    assign local_ctrl_o  = s_q.loc;
    assign fault_o       = s_q.fault;
    assign rd_data_o     = s_q.rd_data;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence star_seen_s;
        (s_q.seq == ST_STAR) && hw_s.star_fb;
    endsequence

    sequence stop_while_running_s;
        (s_q.seq != ST_IDLE) && stop_req;
    endsequence

    a_fault_blocks_ready: assert property ( // see RULE1
        s_q.fault |=> !s_q.ready && s_q.seq == ST_IDLE)
        else $error("Ready while a fault is pending.");
    a_stop_blocks_ready: assert property ( // see RULE2
        stop_act |=> !s_q.ready) else $error("Ready while stop input is active.");
    a_superv_gates_ready: assert property ( // see RULE3
        s_q.cfg[CFG_SUPERV_BIT] && !hw_s.superv |=> !s_q.ready)
        else $error("Ready without drawer supervision input.");
    a_fieldbus_selects: assert property ( // see RULE4
        sel == SEL_FIELDBUS && telegram_i.valid
        |=> s_q.loc == $past(telegram_i.word[TG_LOCAL_BIT]))
        else $error("Fieldbus selection not taken.");
    a_serial_selects: assert property ( // see RULE5
        sel == SEL_SERIAL && coil_wr_i.wr && coil_wr_i.val && coil_wr_i.addr == COIL_SEL_REMOTE
        |=> s_q.rem && !s_q.loc) else $error("Serial remote selection not taken.");
    a_both_modes_block: assert property ( // see RULE9
        s_q.loc && s_q.rem |=> !s_q.ready && ($past(s_q.seq) != ST_IDLE || s_q.seq == ST_IDLE))
        else $error("Ready with local and remote both active.");
    a_cfg_locked: assert property ( // see RULE10
        reg_wr_i.wr && !param_ok && reg_wr_i.addr == STAR_MAX_ON_TIME_ADDR
        |=> $stable(s_q.star_max)) else $error("Timer written without permission.");
    a_star_first: assert property ( // see RULE11
        s_q.seq == ST_IDLE && s_d.seq == ST_STAR
        |=> s_q.coils.star_contactor && !s_q.coils.forward_line_contactor
            && !s_q.coils.reverse_line_contactor) else $error("Star not energized first.");
    a_line_after_star: assert property ( // see RULE12
        (star_seen_s and (!stop_req)) |=> s_q.coils.star_contactor
        && (s_q.coils.forward_line_contactor ^ s_q.coils.reverse_line_contactor))
        else $error("Line contactor missing after star feedback.");
    a_delta_after_gap: assert property ( // see RULE14
        $rose(s_q.coils.delta_contactor) |-> $past(s_q.seq) == ST_GAP && !$past(hw_s.star_fb))
        else $error("Delta closed before star feedback cleared.");
    a_stop_opens_all: assert property ( // see RULE15
        stop_while_running_s |=> s_q.coils == '0) else $error("Contactors left on after stop.");
    a_lines_exclusive: assert property ( // see RULE22
        !(s_q.coils.forward_line_contactor && s_q.coils.reverse_line_contactor))
        else $error("Both line contactors energized.");
endmodule
`default_nettype wire

// ### include/starter_pkg.sv
// Shared constants, types and carriers of the reversing star-delta starter sequencer.
`default_nettype none
package starter_pkg;

    // Register addresses of the serial register interface.
    localparam logic [15:0] CURRENT_DROP_THRESHOLD_ADDR    = 16'h0015;
    localparam logic [15:0] STAR_MAX_ON_TIME_ADDR          = 16'h0021;
    localparam logic [15:0] STAR_TO_DELTA_SWITCH_TIME_ADDR = 16'h0022;
    localparam logic [15:0] DEVICE_CONFIGURATION_ADDR      = 16'h003E;
    localparam logic [15:0] SEQ_STATUS_ADDR                = 16'h0040;
    localparam logic [15:0] FAULT_CLEAR_FIRST_ADDR         = 16'h0041;
    localparam logic [15:0] FAULT_CLEAR_LAST_ADDR          = 16'h006A;

    // Reset values.
    localparam logic [15:0] CURRENT_DROP_THRESHOLD_RST    = 16'h0000;
    localparam logic [15:0] STAR_MAX_ON_TIME_RST          = 16'h01F4;
    localparam logic [15:0] STAR_TO_DELTA_SWITCH_TIME_RST = 16'h0005;
    localparam logic [15:0] DEVICE_CONFIGURATION_RST      = 16'h0000;

    // Fields of the device configuration register.
    localparam int CFG_DEFAULT_BIT   = 0;
    localparam int CFG_PARAM_OK_BIT  = 1;
    localparam int CFG_SEL_LSB       = 2;
    localparam int CFG_SUPERV_BIT    = 5;
    localparam int CFG_TYPE_LSB      = 8;
    localparam int CFG_REMOTE_LSB    = 12;
    localparam int CFG_STOP_INV_BIT  = 14;
    localparam int CFG_START_INV_BIT = 15;
    localparam logic [3:0] TYPE_STAR_DELTA_REV = 4'h3;

    // Coil numbers and telegram bits.
    localparam logic [15:0] COIL_FWD_START  = 16'h0000;
    localparam logic [15:0] COIL_REV_START  = 16'h0001;
    localparam logic [15:0] COIL_STOP       = 16'h0002;
    localparam logic [15:0] COIL_IDENT      = 16'h0003;
    localparam logic [15:0] COIL_SEL_LOCAL  = 16'h000A;
    localparam logic [15:0] COIL_SEL_REMOTE = 16'h000B;
    localparam int TG_FWD_BIT    = 0;
    localparam int TG_REV_BIT    = 1;
    localparam int TG_STOP_BIT   = 2;
    localparam int TG_LOCAL_BIT  = 9;
    localparam int TG_REMOTE_BIT = 10;

    // Timing: timer registers count in units of 10 ms.
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned TIMER_UNIT_NS = 10_000_000;
    localparam int unsigned TICK_CYCLES   = TIMER_UNIT_NS / CLK_PERIOD_NS;
    localparam logic [15:0] FLASH_TICKS   = 16'h0032;

    typedef enum logic [2:0] {
        SEL_FIELDBUS     = 3'h0,
        SEL_SERIAL       = 3'h1,
        SEL_HARDWIRE     = 3'h2,
        SEL_FIXED_LOCAL  = 3'h3,
        SEL_FIXED_REMOTE = 3'h4
    } sel_src_t;

    typedef enum logic [1:0] {
        SRC_HARDWIRE = 2'h0,
        SRC_SERIAL   = 2'h1,
        SRC_FIELDBUS = 2'h2
    } cmd_src_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_STAR  = 5'h02,
        ST_LINE  = 5'h04,
        ST_GAP   = 5'h08,
        ST_DELTA = 5'h10
    } seq_state_t;

    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [15:0] data;
    } reg_wr_t;

    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic        val;
    } coil_wr_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } telegram_t;

    typedef struct packed {
        logic stop_n;
        logic fwd_start;
        logic rev_start;
        logic superv;
        logic sel_local;
        logic sel_remote;
        logic reset_alarm;
        logic star_fb;
    } hw_in_t;

    typedef struct packed {
        logic forward_line_contactor;
        logic reverse_line_contactor;
        logic star_contactor;
        logic delta_contactor;
    } coils_t;

endpackage
`default_nettype wire

// ### hdl/pin_sync.sv
// Two-flop synchroniser for asynchronous pin inputs.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             nrst_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync needs WIDTH of at least one.");
    end

    always_comb begin
        s_d      = s_q;
        s_d.meta = d_i;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q_o = s_q.sync;
endmodule
`default_nettype wire

// ### verification/contactor_model.sv
// Contactor model that answers the star coil with its feedback contact.
`timescale 1ns/1ns
`default_nettype none
module contactor_model #(
    parameter int DELAY = 3
) (
    // Clock
    input  wire logic sys_clk_i,
    // Coil in, feedback out
    input  wire logic star_i,
    output logic      star_fb_o
);
    logic [7:0] pipe_q = 8'h00;
    // The contact follows the coil late, so the sequencer must really wait for it.
    always_ff @(posedge sys_clk_i) pipe_q <= {pipe_q[6:0], star_i};
    assign star_fb_o = pipe_q[DELAY-1];
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench of the reversing star-delta starter sequencer.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import starter_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        nrst_i    = 1'b0;
    logic [6:0]  pins      = 7'h40;
    wire logic   fb;
    hw_in_t      hw_w;
    logic [15:0] rd_addr   = 16'h0000;
    logic [15:0] rd_data;
    reg_wr_t     reg_wr    = '0;
    coil_wr_t    coil_wr   = '0;
    telegram_t   tg        = '0;
    logic        fault_ev  = 1'b0;
    logic [15:0] cur       = 16'h0100;
    coils_t      coils;
    logic        ready;
    logic        loc;
    logic        flt;
    int          n_fail       = 0;
    int          total_checks = 0;
    assign hw_w = {pins, fb};
    star_delta_reversing_starter_seq #(.TICK_CYCLES_P(4)) uut (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .hw_i(hw_w), .current_i(cur),
        .fault_event_i(fault_ev), .reg_wr_i(reg_wr), .coil_wr_i(coil_wr), .rd_addr_i(rd_addr),
        .rd_data_o(rd_data), .telegram_i(tg), .coils_o(coils), .ready_ident_o(ready),
        .local_ctrl_o(loc), .fault_o(flt));
    contactor_model cm (.sys_clk_i(sys_clk_i), .star_i(coils.star_contactor), .star_fb_o(fb));
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        tick(1);
        reg_wr = '{1'b1, a, d};
        tick(1);
        reg_wr = '0;
    endtask
    task automatic coil(input logic [15:0] a);
        tick(1);
        coil_wr = '{1'b1, a, 1'b1};
        tick(1);
        coil_wr = '0;
        tick(3);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        tick(1);
        rd_addr = a;
        tick(2);
        check(rd_data, exp);
    endtask
    // Bounded wait for a coil pattern; patterns are {fwd, rev, star, delta}.
    task automatic wait_coils(input logic [3:0] exp);
        for (int i = 0; i < 200 && coils !== exp; i++) tick(1);
        check({12'h000, coils}, {12'h000, exp});
    endtask
    task automatic t_regs();
        rd_chk(STAR_MAX_ON_TIME_ADDR, STAR_MAX_ON_TIME_RST);
        wr(STAR_MAX_ON_TIME_ADDR, 16'h0003);
        rd_chk(STAR_MAX_ON_TIME_ADDR, STAR_MAX_ON_TIME_RST);
        wr(DEVICE_CONFIGURATION_ADDR, 16'h1307);
        rd_chk(DEVICE_CONFIGURATION_ADDR, 16'h0002);
        wr(DEVICE_CONFIGURATION_ADDR, 16'h1307);
        rd_chk(DEVICE_CONFIGURATION_ADDR, 16'h1307);
        wr(STAR_MAX_ON_TIME_ADDR, 16'h0003);
        wr(STAR_TO_DELTA_SWITCH_TIME_ADDR, 16'h0002);
        rd_chk(STAR_TO_DELTA_SWITCH_TIME_ADDR, 16'h0002);
        rd_chk(16'h0077, 16'h0000);
    endtask
    task automatic t_fwd();
        coil(COIL_SEL_LOCAL);
        check({14'h0, ready, loc}, 16'h0003);
        pins = 7'h60;
        wait_coils(4'b0010);
        wait_coils(4'b1010);
        wait_coils(4'b1000);
        wait_coils(4'b1001);
        pins = 7'h50;
        tick(6);
        check({12'h000, coils}, 16'h0009);
        pins = 7'h00;
        tick(5);
        check({11'h000, coils, ready}, 16'h0000);
        pins = 7'h40;
    endtask
    task automatic t_rev();
        coil(COIL_SEL_REMOTE);
        check({15'h0, loc}, 16'h0000);
        pins = 7'h60;
        tick(6);
        check({12'h000, coils}, 16'h0000);
        pins = 7'h40;
        // A long star time means only the current drop can end the star phase in time.
        wr(STAR_MAX_ON_TIME_ADDR, 16'h0100);
        wr(CURRENT_DROP_THRESHOLD_ADDR, 16'h0080);
        coil(COIL_REV_START);
        wait_coils(4'b0110);
        cur = 16'h0040;
        wait_coils(4'b0100);
        wait_coils(4'b0101);
        coil(COIL_STOP);
        check({12'h000, coils}, 16'h0000);
    endtask
    task automatic t_bus();
        wr(DEVICE_CONFIGURATION_ADDR, 16'h1323);
        tick(3);
        check({15'h0, ready}, 16'h0000);
        pins = 7'h48;
        tg = '{1'b1, 16'h0600};
        tick(1);
        tg = '0;
        tick(3);
        check({15'h0, ready}, 16'h0000);
        tg = '{1'b1, 16'h0200};
        tick(1);
        tg = '0;
        tick(3);
        check({14'h0, ready, loc}, 16'h0003);
        fault_ev = 1'b1;
        tick(1);
        fault_ev = 1'b0;
        tick(3);
        check({14'h0, ready, flt}, 16'h0001);
        coil(COIL_IDENT);
        for (int i = 0; i < 500 && ready !== 1'b1; i++) tick(1);
        check({15'h0, ready}, 16'h0001);
        for (int i = 0; i < 500 && ready !== 1'b0; i++) tick(1);
        check({15'h0, ready}, 16'h0000);
        wr(FAULT_CLEAR_FIRST_ADDR, 16'h0000);
        tick(3);
        check({14'h0, ready, flt}, 16'h0002);
        wr(DEVICE_CONFIGURATION_ADDR, 16'h1313);
        tick(3);
        check({14'h0, ready, loc}, 16'h0002);
        wr(DEVICE_CONFIGURATION_ADDR, 16'h130F);
        tick(3);
        check({14'h0, ready, loc}, 16'h0003);
        pins = 7'h42;
        wr(DEVICE_CONFIGURATION_ADDR, 16'h130B);
        tick(3);
        check({14'h0, ready, loc}, 16'h0002);
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    // The whole run needs well under a tenth of this span.
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
    initial begin
        tick(6);
        nrst_i = 1'b1;
        tick(3);
        t_regs();
        t_fwd();
        t_rev();
        t_bus();
        end_of_test();
    end
endmodule
`default_nettype wire
